// ===== testbench/ssw_checker.sv
// Port-level assertions for the supply supervisor and wake control block
`timescale 1ns/1ps
module ssw_checker #(
    parameter HOLD_SLOW_CYC = 40,
    parameter SETTLE_NORM_CYC = 40
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_soft_clear,
    input wire o_standby,
    input wire o_cpu_hold,
    input wire o_locked,
    input wire [1:0] o_core_sup_state,
    input wire o_subclk_overspeed,
    input wire [2:0] o_main_clk_divider,
    input wire o_core_reset_req
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    // Completed clock configuration write, the only legal cause of a divider change
    wire wr_cfg = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == 12'h008);

    AST_PREADY_WAIT: assert property ($rose(i_penable) && i_psel |->
        !o_pready ##1 o_pready)
        else $error("ready not after exactly one wait state");
    AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    AST_SLVERR_READY: assert property (o_pslverr |-> o_pready)
        else $error("error response without ready");
    AST_CORE_RST_PULSE: assert property (o_core_reset_req |=> !o_core_reset_req)
        else $error("core reset request longer than one cycle");
    AST_DIV_BY_WRITE: assert property (!$stable(o_main_clk_divider) |->
        $past(wr_cfg) || $past(wr_cfg, 2))
        else $error("divider changed without a configuration write");
    AST_HOLD_AFTER_WAKE: assert property ($fell(o_standby) && !$past(o_locked) |->
        o_cpu_hold [*8])
        else $error("execution released too early after wake");
    // A later wake restarts the overshoot window, so the window may run on past it
    AST_SUBCLK_WINDOW: assert property ($rose(o_subclk_overspeed) |->
        o_subclk_overspeed [*8] ##[1:760] (!o_subclk_overspeed || $fell(o_standby)))
        else $error("subsystem clock overspeed window wrong length");
    AST_STATE_CODE: assert property (o_core_sup_state != 2'h3)
        else $error("core supervisor state code out of range");
    AST_LOCK_EXIT: assert property ($fell(o_locked) |->
        $past(i_soft_clear, 2) || $past(i_soft_clear, 4) || $past(i_soft_clear, 6))
        else $error("lock released without soft clear");
    AST_LOCK_STANDBY: assert property (o_locked && $past(o_locked) |->
        o_standby && o_cpu_hold)
        else $error("lock without standby and execution hold");

    // Main scenarios reached
    COV_LOCK: cover property (o_locked);
    COV_SUBCLK: cover property ($rose(o_subclk_overspeed));
    COV_LEVEL_RESET: cover property (o_core_reset_req);
endmodule

bind ssw_supervisor_ctrl ssw_checker #(.HOLD_SLOW_CYC(HOLD_SLOW_CYC),
    .SETTLE_NORM_CYC(SETTLE_NORM_CYC)) chk_u (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_soft_clear(i_soft_clear), .o_standby(o_standby), .o_cpu_hold(o_cpu_hold),
    .o_locked(o_locked), .o_core_sup_state(o_core_sup_state),
    .o_subclk_overspeed(o_subclk_overspeed), .o_main_clk_divider(o_main_clk_divider),
    .o_core_reset_req(o_core_reset_req));

// ===== testbench/tb_top.sv
// Self-checking bench for the supply supervisor and wake control block
`timescale 1ns/1ps
`include "ssw_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    localparam HS = 40;
    localparam SN = 40;
    reg clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, wake = 0, sclr = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [15:0] lfsr = 16'h58ac; // Seed 22700
    reg [12:0] cfg, ncfg;
    reg [5:0] cc, sc;
    reg err, rf, slow, mo, so, rst_seen;
    wire [31:0] prdata;
    wire pready, pslverr, irq, stby, hold, lock, movs, sovs, gate, crst;
    wire [1:0] cs, cm, ss, sm, lvl;
    wire [2:0] div;
    integer miscompares = 0, cmp_count = 0, tick = 0, i, n, t0, ds;

    ssw_supervisor_ctrl #(.HOLD_SLOW_CYC(HS), .SETTLE_NORM_CYC(SN)) dut_u (
        .i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_wake_req(wake), .i_soft_clear(sclr), .o_irq(irq),
        .o_standby(stby), .o_cpu_hold(hold), .o_locked(lock), .o_core_sup_state(cs),
        .o_core_mon_state(cm), .o_supply_sup_state(ss), .o_supply_mon_state(sm),
        .o_main_overspeed(movs), .o_subclk_overspeed(sovs), .o_subclk_gate_en(gate),
        .o_main_clk_divider(div), .o_core_level(lvl), .o_core_reset_req(crst));

    always #4 clk = ~clk;
    // Cycle count and sticky capture of the one-cycle level reset pulse
    always @(posedge clk) begin
        tick <= tick + 1;
        if (crst === 1'b1) rst_seen <= 1'b1;
    end

    function [15:0] lfsr_next(input [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected unit state: active follows performance, deep follows lpm and auto control
    function [1:0] mapst(input en, input lpm, input fp, input au, input dp);
        if (!en || (dp && !lpm)) mapst = 2'h0;
        else if (!dp || !au) mapst = fp ? 2'h2 : 2'h1;
        else mapst = fp ? 2'h1 : 2'h0;
    endfunction
    function [4:0] thr(input [1:0] l);
        thr = (l == 0) ? 5'd4 : (l == 1) ? 5'd7 : (l == 2) ? 5'd11 : 5'd14;
    endfunction

    task end_sim;
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; request held until ready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk); psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
            @(posedge clk); pen <= 1;
            k = 0;
            do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
            if (k >= 50) begin miscompares++; end_sim; end
            rd = prdata; err = pslverr; psel <= 0; pen <= 0;
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        apb(0, `SSW_ADDR_CORE_CTRL, 0); `CHK("core_ctrl", 32'h1, rd)
        apb(0, `SSW_ADDR_SUPPLY_CTRL, 0); `CHK("supply_ctrl", 32'h1, rd)
        apb(0, `SSW_ADDR_CLK_CFG, 0); `CHK("clk_cfg", 32'hc00, rd)
        apb(0, `SSW_ADDR_IRQ_MASK, 0); `CHK("irq_mask", 32'h0, rd)
        apb(1, 12'h01c, 32'hffff); `CHK("bad_wr", 1'b1, err)
        apb(0, 12'h01c, 0); `CHK("bad_rd", 33'h100000000, {err, rd})
        cfg = 13'hc00;
        cc = 6'h01;
        // Every core side setting, random supply side and clock settings
        for (i = 0; i < 64; i++) begin
            lfsr = lfsr_next(lfsr); ncfg = lfsr[12:0];
            ncfg[12] = ncfg[12] | ncfg[11];
            rf = (ncfg[4:3] > cfg[4:3]) && cc[0] && cc[1];
            rst_seen = 0;
            apb(1, `SSW_ADDR_CLK_CFG, {19'h0, ncfg});
            if (!rf) cfg = ncfg;
            cyc(3);
            `CHK("level_reset", rf, rst_seen)
            `CHK("level", cfg[4:3], lvl)
            `CHK("divider", cfg[2:0], div)
            cc = i; lfsr = lfsr_next(lfsr); sc = lfsr[5:0];
            apb(1, `SSW_ADDR_CORE_CTRL, {26'h0, cc}); apb(1, `SSW_ADDR_SUPPLY_CTRL, {26'h0, sc});
            t0 = tick;
            cyc(2);
            `CHK("core_sup", mapst(cc[0], cc[2], cc[1], cc[5], 0), cs)
            `CHK("sup_mon", mapst(sc[3], 1'b1, sc[4], sc[5], 0), sm)
            apb(0, `SSW_ADDR_STATUS, 0); `CHK("flags_busy", 2'b11, rd[1:0])
            n = 0;
            while (rd[1:0] !== 2'b00 && n < 200) begin apb(0, `SSW_ADDR_STATUS, 0); n++; end
            ds = (cc[1] || sc[1]) ? 250 : SN;
            `CHK("settle", 1'b1, tick - t0 >= ds - 4 && tick - t0 <= ds + 12)
            apb(1, `SSW_ADDR_POWER_MODE, 32'h1);
            cyc(4);
            `CHK("standby", 1'b1, stby)
            `CHK("core_sup_dp", mapst(cc[0], cc[2], cc[1], cc[5], 1), cs)
            `CHK("core_mon_dp", mapst(cc[3], 1'b1, cc[4], cc[5], 1), cm)
            `CHK("sup_sup_dp", mapst(sc[0], sc[2], sc[1], sc[5], 1), ss)
            `CHK("sup_mon_dp", mapst(sc[3], 1'b1, sc[4], sc[5], 1), sm)
            // No earlier wake window yet, so only the request bit keeps the clock
            if (i == 0) `CHK("gate_dp", cfg[12], gate)
            // Wake well past the entry window, then time the execution hold-off
            cyc(130); wake <= 1; mo = 0; so = 0; n = 0;
            while (hold !== 1'b0 && n < 1000) begin
                @(posedge clk); mo |= movs; so |= sovs; n++;
            end
            wake <= 0;
            slow = (cc[0] && !cc[1]) || (cc[3] && !cc[4]);
            ds = slow ? HS : 250;
            `CHK("hold_len", 1'b1, n >= ds && n <= ds + 12)
            rf = !slow && cfg[2:0] == 0 && cfg[10] && cfg[9:5] > thr(cfg[4:3]);
            `CHK("main_ovs", rf, mo)
            `CHK("sub_ovs", cfg[11], so)
            if (i == 0) begin
                `CHK("irq_masked", 1'b0, irq)
                apb(1, `SSW_ADDR_IRQ_MASK, 32'h4); cyc(3); `CHK("irq_on", 1'b1, irq)
                apb(1, `SSW_ADDR_IRQ_STATUS, 32'h1f); cyc(3); `CHK("irq_off", 1'b0, irq)
            end
        end
        // Normal performance first, so the level raise lands without a reset
        apb(1, `SSW_ADDR_CORE_CTRL, 32'h1); apb(1, `SSW_ADDR_CLK_CFG, 32'h1c18);
        cyc(3); `CHK("level_up", 2'h3, lvl)
        // Standby entered while settling, wake inside the entry window
        apb(1, `SSW_ADDR_CORE_CTRL, 32'h1);
        apb(1, `SSW_ADDR_POWER_MODE, 32'h1);
        cyc(20); wake <= 1; cyc(12); wake <= 0;
        `CHK("locked", 1'b1, lock)
        cyc(20); `CHK("still_locked", 1'b1, lock)
        sclr <= 1; cyc(10); sclr <= 0; cyc(10);
        `CHK("unlocked", 1'b0, lock)
        end_sim;
    end
endmodule

// ===== verilog/ssw_defs.vh
// Constants for the supply supervisor and wake control block
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH

// Clock period and documented times, in ns
`define SSW_CLK_NS 8
`define SSW_T_HOLD_SLOW_NS 150000
`define SSW_T_HOLD_FAST_NS 2000
`define SSW_T_OVERSPEED_NS 6000
`define SSW_T_ENTRY_WIN_NS 1000
`define SSW_T_SETTLE_FULL_NS 2000
`define SSW_T_SETTLE_NORM_NS 150000

// APB byte offsets
`define SSW_ADDR_CORE_CTRL 12'h000
`define SSW_ADDR_SUPPLY_CTRL 12'h004
`define SSW_ADDR_CLK_CFG 12'h008
`define SSW_ADDR_POWER_MODE 12'h00c
`define SSW_ADDR_STATUS 12'h010
`define SSW_ADDR_IRQ_STATUS 12'h014
`define SSW_ADDR_IRQ_MASK 12'h018

// Side control fields (same layout for core and supply side)
`define SSW_CTL_W 6
`define SSW_CTL_SUP_EN 0
`define SSW_CTL_SUP_FP 1
`define SSW_CTL_SUP_LPM 2
`define SSW_CTL_MON_EN 3
`define SSW_CTL_MON_FP 4
`define SSW_CTL_AUTO 5
`define SSW_CORE_CTL_RST 6'h01
`define SSW_SUPPLY_CTL_RST 6'h01

// Clock configuration fields
`define SSW_CFG_W 13
`define SSW_CFG_DIV_LSB 0
`define SSW_CFG_DIV_MSB 2
`define SSW_CFG_LVL_LSB 3
`define SSW_CFG_LVL_MSB 4
`define SSW_CFG_OSC_LSB 5
`define SSW_CFG_OSC_MSB 9
`define SSW_CFG_MAIN_OSC 10
`define SSW_CFG_SUB_OSC 11
`define SSW_CFG_SUB_REQ 12
`define SSW_CFG_RST 13'h0c00

// Power mode register
`define SSW_MODE_DEEP 0

// Interrupt events
`define SSW_IRQ_W 5
`define SSW_IRQ_CORE_SETTLED 0
`define SSW_IRQ_SUPPLY_SETTLED 1
`define SSW_IRQ_WAKE_DONE 2
`define SSW_IRQ_LOCKED 3
`define SSW_IRQ_LEVEL_RESET 4

// Overspeed thresholds in MHz per core level
`define SSW_THR_L0 5'd4
`define SSW_THR_L1 5'd7
`define SSW_THR_L2 5'd11
`define SSW_THR_L3 5'd14

// Supervisor states
`define SSW_ST_OFF 2'h0
`define SSW_ST_NORMAL 2'h1
`define SSW_ST_FULL 2'h2

`define SSW_TMR_W 16

`endif

// ===== verilog/ssw_supervisor_ctrl.v
// Supply supervisor and wake control: APB registers, mode mapping, wake hold-off
// Functional notes
// - Normal-performance low side holds CPU execution 150 us after deep wake.
// - Low side disabled or full performance shortens the hold-off to 2 us.
// - Overspeed risk when main clock from oscillator exceeds 4/7/11/14 MHz.
// - Subsystem clock from oscillator stays ungated, may run fast 6 us.
// - Full-performance settling is about 2 us; level raise then resets.
// - Normal-performance settling delay is about 150 us.
// - Slow wake when low side enabled in normal performance, else fast.
// - Core supervisor deep-standby state follows enable, lpm, auto, performance.
// - Supply side uses the same mapping under its auto control bit.
// - Missed wake near entry locks until reset or soft power-up clear.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "ssw_defs.vh"
module ssw_supervisor_ctrl #(
    parameter HOLD_SLOW_CYC = (`SSW_T_HOLD_SLOW_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS,
    parameter SETTLE_NORM_CYC = (`SSW_T_SETTLE_NORM_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_wake_req,
    input wire i_soft_clear,
    output reg o_irq,
    output reg o_standby,
    output reg o_cpu_hold,
    output reg o_locked,
    output reg [1:0] o_core_sup_state,
    output reg [1:0] o_core_mon_state,
    output reg [1:0] o_supply_sup_state,
    output reg [1:0] o_supply_mon_state,
    output reg o_main_overspeed,
    output reg o_subclk_overspeed,
    output reg o_subclk_gate_en,
    output reg [2:0] o_main_clk_divider,
    output reg [1:0] o_core_level,
    output reg o_core_reset_req
);
    // Short delays, least times rounded up to whole cycles
    localparam HOLD_FAST_I = (`SSW_T_HOLD_FAST_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS;
    localparam OVERSPEED_I = `SSW_T_OVERSPEED_NS / `SSW_CLK_NS;
    localparam ENTRY_WIN_I = `SSW_T_ENTRY_WIN_NS / `SSW_CLK_NS;
    localparam SETTLE_FULL_I = (`SSW_T_SETTLE_FULL_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS;
    localparam [`SSW_TMR_W-1:0] HOLD_FAST_CYC = HOLD_FAST_I[`SSW_TMR_W-1:0];
    localparam [`SSW_TMR_W-1:0] OVERSPEED_CYC = OVERSPEED_I[`SSW_TMR_W-1:0];
    localparam [`SSW_TMR_W-1:0] ENTRY_WIN_CYC = ENTRY_WIN_I[`SSW_TMR_W-1:0];
    localparam [`SSW_TMR_W-1:0] SETTLE_FULL_CYC = SETTLE_FULL_I[`SSW_TMR_W-1:0];
    localparam [`SSW_TMR_W-1:0] HOLD_SLOW = HOLD_SLOW_CYC[`SSW_TMR_W-1:0];
    localparam [`SSW_TMR_W-1:0] SETTLE_NORM = SETTLE_NORM_CYC[`SSW_TMR_W-1:0];

    // Power states
    localparam [1:0] ST_ACTIVE = 2'h0;
    localparam [1:0] ST_STANDBY = 2'h1;
    localparam [1:0] ST_WAKE = 2'h2;
    localparam [1:0] ST_LOCK = 2'h3;

    // Supervisor state in the present power mode; monitors pass lpm_en = 1
    function [1:0] map_state;
        input en;
        input lpm_en;
        input fp;
        input auto_ctl;
        input deep;
        begin
            if (!en)
                map_state = `SSW_ST_OFF;
            else if (!deep)
                map_state = fp ? `SSW_ST_FULL : `SSW_ST_NORMAL;
            else if (!lpm_en)
                map_state = `SSW_ST_OFF;
            else if (!auto_ctl)
                map_state = fp ? `SSW_ST_FULL : `SSW_ST_NORMAL;
            else
                map_state = fp ? `SSW_ST_NORMAL : `SSW_ST_OFF;
        end
    endfunction

    // Overspeed threshold in MHz for a core level
    function [4:0] osc_limit;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h0: osc_limit = `SSW_THR_L0;
                2'h1: osc_limit = `SSW_THR_L1;
                2'h2: osc_limit = `SSW_THR_L2;
                default: osc_limit = `SSW_THR_L3;
            endcase
        end
    endfunction

    reg [`SSW_CTL_W-1:0] core_side_control_q;
    reg [`SSW_CTL_W-1:0] supply_side_control_q;
    reg [`SSW_CFG_W-1:0] clk_cfg_q;
    reg [`SSW_IRQ_W-1:0] irq_status_q;
    reg [`SSW_IRQ_W-1:0] irq_mask_q;
    reg [1:0] state_q;
    reg entry_dirty_q;
    reg wake_prev_q;
    reg [`SSW_IRQ_W-1:0] irq_set;
    reg [31:0] rdata_d;
    reg addr_ok;
    reg [1:0] state_d;

    wire [1:0] pins_sync;
    wire wake_s;
    wire soft_clear_s;
    wire core_busy;
    wire core_done;
    wire supply_busy;
    wire supply_done;
    wire hold_busy;
    wire hold_done;
    wire fast_busy;
    wire win_busy;
    wire access;
    wire wr_en;
    wire wake_rise;
    wire core_slow_wake;
    wire deep;
    wire [1:0] new_level;
    wire level_raise;
    wire enter_deep;

    // Pins are asynchronous to the system clock
    ssw_sync #(
        .W(2)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_async({i_soft_clear, i_wake_req}),
        .o_sync(pins_sync)
    );
    assign wake_s = pins_sync[0];
    assign soft_clear_s = pins_sync[1];

    // APB: registered ready gives one wait state; effects land on the pready edge
    assign access = i_psel && i_penable && o_pready;
    assign wr_en = access && i_pwrite && addr_ok;
    assign wake_rise = wake_s && !wake_prev_q;
    assign deep = (state_q == ST_STANDBY);
    assign new_level = i_pwdata[`SSW_CFG_LVL_MSB:`SSW_CFG_LVL_LSB];
    assign enter_deep = wr_en && (i_paddr == `SSW_ADDR_POWER_MODE)
        && i_pwdata[`SSW_MODE_DEEP] && (state_q == ST_ACTIVE);

    // Slow wake while either low-side unit runs enabled in normal performance
    assign core_slow_wake =
        (core_side_control_q[`SSW_CTL_SUP_EN] && !core_side_control_q[`SSW_CTL_SUP_FP])
        || (core_side_control_q[`SSW_CTL_MON_EN]
        && !core_side_control_q[`SSW_CTL_MON_FP]);

    // Raising the level with a full-performance low supervisor trips a reset
    assign level_raise = wr_en && (i_paddr == `SSW_ADDR_CLK_CFG)
        && (new_level > clk_cfg_q[`SSW_CFG_LVL_MSB:`SSW_CFG_LVL_LSB])
        && core_side_control_q[`SSW_CTL_SUP_EN]
        && core_side_control_q[`SSW_CTL_SUP_FP];

    // Settling timers restart on every write to their side's control register
    ssw_timer u_core_settle (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_load(wr_en && (i_paddr == `SSW_ADDR_CORE_CTRL)),
        .i_count(i_pwdata[`SSW_CTL_SUP_FP] ? SETTLE_FULL_CYC : SETTLE_NORM),
        .o_busy(core_busy),
        .o_done(core_done)
    );
    ssw_timer u_supply_settle (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_load(wr_en && (i_paddr == `SSW_ADDR_SUPPLY_CTRL)),
        .i_count(i_pwdata[`SSW_CTL_SUP_FP] ? SETTLE_FULL_CYC : SETTLE_NORM),
        .o_busy(supply_busy),
        .o_done(supply_done)
    );

    // Execution hold-off after a deep wake
    ssw_timer u_hold (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_load(deep && wake_rise && !win_busy),
        .i_count(core_slow_wake ? HOLD_SLOW : HOLD_FAST_CYC),
        .o_busy(hold_busy),
        .o_done(hold_done)
    );

    // Oscillator overshoot window right after a deep wake
    ssw_timer u_fast (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_load(deep && wake_rise && !win_busy),
        .i_count(OVERSPEED_CYC),
        .o_busy(fast_busy),
        .o_done()
    );

    // Entry window in which a wake event can be lost
    ssw_timer u_entry_win (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_load(enter_deep),
        .i_count(ENTRY_WIN_CYC),
        .o_busy(win_busy),
        .o_done()
    );

    // Address decode and read mux
    always @* begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (i_paddr)
            `SSW_ADDR_CORE_CTRL: rdata_d[`SSW_CTL_W-1:0] = core_side_control_q;
            `SSW_ADDR_SUPPLY_CTRL: rdata_d[`SSW_CTL_W-1:0] = supply_side_control_q;
            `SSW_ADDR_CLK_CFG: rdata_d[`SSW_CFG_W-1:0] = clk_cfg_q;
            `SSW_ADDR_POWER_MODE: rdata_d[`SSW_MODE_DEEP] = deep;
            `SSW_ADDR_STATUS: rdata_d[15:0] = {o_supply_mon_state, o_supply_sup_state,
                o_core_mon_state, o_core_sup_state, 2'h0, state_q,
                o_locked, o_cpu_hold, supply_busy, core_busy};
            `SSW_ADDR_IRQ_STATUS: rdata_d[`SSW_IRQ_W-1:0] = irq_status_q;
            `SSW_ADDR_IRQ_MASK: rdata_d[`SSW_IRQ_W-1:0] = irq_mask_q;
            default: addr_ok = 1'b0;
        endcase
    end

    // Bus slave handshake
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_prdata <= rdata_d;
            o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
        end
    end

    // Software-written registers
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            core_side_control_q <= `SSW_CORE_CTL_RST;
            supply_side_control_q <= `SSW_SUPPLY_CTL_RST;
            clk_cfg_q <= `SSW_CFG_RST;
            irq_mask_q <= {`SSW_IRQ_W{1'b0}};
        end else if (wr_en) begin
            if (i_paddr == `SSW_ADDR_CORE_CTRL)
                core_side_control_q <= i_pwdata[`SSW_CTL_W-1:0];
            if (i_paddr == `SSW_ADDR_SUPPLY_CTRL)
                supply_side_control_q <= i_pwdata[`SSW_CTL_W-1:0];
            if (i_paddr == `SSW_ADDR_CLK_CFG && !level_raise)
                clk_cfg_q <= i_pwdata[`SSW_CFG_W-1:0];
            if (i_paddr == `SSW_ADDR_IRQ_MASK)
                irq_mask_q <= i_pwdata[`SSW_IRQ_W-1:0];
        end
    end

    // Power state machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_ACTIVE: begin
                if (enter_deep)
                    state_d = ST_STANDBY;
            end
            ST_STANDBY: begin
                // Wake during the entry window after an unsettled write is lost
                if (wake_rise && win_busy && entry_dirty_q)
                    state_d = ST_LOCK;
                else if (wake_rise && !win_busy)
                    state_d = ST_WAKE;
            end
            ST_WAKE: begin
                if (hold_done)
                    state_d = ST_ACTIVE;
            end
            ST_LOCK: begin
                if (soft_clear_s)
                    state_d = ST_ACTIVE;
            end
            default: state_d = ST_ACTIVE;
        endcase
    end

    // Sticky events
    always @* begin
        irq_set = {`SSW_IRQ_W{1'b0}};
        irq_set[`SSW_IRQ_CORE_SETTLED] = core_done;
        irq_set[`SSW_IRQ_SUPPLY_SETTLED] = supply_done;
        irq_set[`SSW_IRQ_WAKE_DONE] = (state_q == ST_WAKE) && hold_done;
        irq_set[`SSW_IRQ_LOCKED] = (state_q != ST_LOCK) && (state_d == ST_LOCK);
        irq_set[`SSW_IRQ_LEVEL_RESET] = level_raise;
    end

    // State, status and interrupt flops; a set beats a same-cycle clear
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_ACTIVE;
            entry_dirty_q <= 1'b0;
            wake_prev_q <= 1'b0;
            irq_status_q <= {`SSW_IRQ_W{1'b0}};
            o_irq <= 1'b0;
        end else begin
            state_q <= state_d;
            wake_prev_q <= wake_s;
            if (enter_deep)
                entry_dirty_q <= core_busy || supply_busy;
            if (wr_en && i_paddr == `SSW_ADDR_IRQ_STATUS)
                irq_status_q <= irq_set | (irq_status_q & ~i_pwdata[`SSW_IRQ_W-1:0]);
            else
                irq_status_q <= irq_set | irq_status_q;
            o_irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // Registered outputs toward the rest of the chip
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_standby <= 1'b0;
            o_cpu_hold <= 1'b0;
            o_locked <= 1'b0;
            o_core_sup_state <= `SSW_ST_OFF;
            o_core_mon_state <= `SSW_ST_OFF;
            o_supply_sup_state <= `SSW_ST_OFF;
            o_supply_mon_state <= `SSW_ST_OFF;
            o_main_overspeed <= 1'b0;
            o_subclk_overspeed <= 1'b0;
            o_subclk_gate_en <= 1'b0;
            o_main_clk_divider <= 3'h0;
            o_core_level <= 2'h0;
            o_core_reset_req <= 1'b0;
        end else begin
            o_standby <= (state_q == ST_STANDBY) || (state_q == ST_LOCK);
            o_cpu_hold <= (state_q != ST_ACTIVE) || hold_busy;
            o_locked <= (state_q == ST_LOCK);
            o_core_sup_state <= map_state(core_side_control_q[`SSW_CTL_SUP_EN],
                core_side_control_q[`SSW_CTL_SUP_LPM], core_side_control_q[`SSW_CTL_SUP_FP],
                core_side_control_q[`SSW_CTL_AUTO], deep);
            o_core_mon_state <= map_state(core_side_control_q[`SSW_CTL_MON_EN], 1'b1,
                core_side_control_q[`SSW_CTL_MON_FP], core_side_control_q[`SSW_CTL_AUTO],
                deep);
            o_supply_sup_state <= map_state(supply_side_control_q[`SSW_CTL_SUP_EN],
                supply_side_control_q[`SSW_CTL_SUP_LPM],
                supply_side_control_q[`SSW_CTL_SUP_FP],
                supply_side_control_q[`SSW_CTL_AUTO], deep);
            o_supply_mon_state <= map_state(supply_side_control_q[`SSW_CTL_MON_EN], 1'b1,
                supply_side_control_q[`SSW_CTL_MON_FP],
                supply_side_control_q[`SSW_CTL_AUTO], deep);
            // Undivided oscillator clock above the level limit with a short mask
            o_main_overspeed <= fast_busy && !core_slow_wake
                && clk_cfg_q[`SSW_CFG_MAIN_OSC]
                && (clk_cfg_q[`SSW_CFG_DIV_MSB:`SSW_CFG_DIV_LSB] == 3'h0)
                && (clk_cfg_q[`SSW_CFG_OSC_MSB:`SSW_CFG_OSC_LSB]
                > osc_limit(clk_cfg_q[`SSW_CFG_LVL_MSB:`SSW_CFG_LVL_LSB]));
            // The subsystem clock gets no mask, so its overshoot is visible
            o_subclk_overspeed <= fast_busy && clk_cfg_q[`SSW_CFG_SUB_OSC];
            o_subclk_gate_en <= clk_cfg_q[`SSW_CFG_SUB_REQ] || !deep || fast_busy;
            o_main_clk_divider <= clk_cfg_q[`SSW_CFG_DIV_MSB:`SSW_CFG_DIV_LSB];
            o_core_level <= clk_cfg_q[`SSW_CFG_LVL_MSB:`SSW_CFG_LVL_LSB];
            o_core_reset_req <= level_raise;
        end
    end
endmodule

// ===== verilog/ssw_sync.v
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ssw_sync #(
    parameter W = 2
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ===== verilog/ssw_timer.v
// Loadable down-counter used for settling, hold-off and window delays
`timescale 1ns/1ps
`include "ssw_defs.vh"
module ssw_timer (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_load,
    input wire [`SSW_TMR_W-1:0] i_count,
    output wire o_busy,
    output wire o_done
);
    reg [`SSW_TMR_W-1:0] cnt_q;

    // A reload restarts the delay from its full length
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= {`SSW_TMR_W{1'b0}};
        end else if (i_load) begin
            cnt_q <= i_count;
        end else if (cnt_q != {`SSW_TMR_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign o_busy = (cnt_q != {`SSW_TMR_W{1'b0}});
    assign o_done = (cnt_q == {{(`SSW_TMR_W-1){1'b0}}, 1'b1}) && !i_load;
endmodule
